// file: common/weigh_regs_pkg.sv
// package: holding-register map, status word layout and command bits
package weigh_regs_pkg;
    localparam int          DATA_W        = 16;
    localparam int          ADDR_W        = 16;
    localparam logic [15:0] ADDR_GROSS    = 16'h9c41;
    localparam logic [15:0] ADDR_TARE     = 16'h9c42;
    localparam logic [15:0] ADDR_COMMAND  = 16'h9c43;
    localparam logic [15:0] ADDR_STATUS   = 16'h9c44;
    localparam int          ST_SIGN       = 0;
    localparam int          ST_STABLE     = 1;
    localparam int          ST_OVERFLOW   = 2;
    localparam int          ST_DP_LSB     = 3;
    localparam int          ST_DP_MSB     = 5;
    localparam int          ST_UNIT_KG    = 10;
    localparam int          CMD_TARE      = 0;
    localparam int          CMD_CLEAR     = 1;
    localparam int          CMD_ZERO      = 2;
    localparam logic [2:0]  DP_NONE       = 3'h2;
    localparam logic [2:0]  DP_ONE        = 3'h3;
    localparam logic [2:0]  DP_TWO        = 3'h4;
    localparam logic [2:0]  DP_THREE      = 3'h5;
    localparam logic [2:0]  DP_FOUR       = 3'h6;
    localparam logic [2:0]  DP_NONE_ALT   = 3'h7;
    localparam logic [15:0] RESET_WORD    = 16'h0000;
    localparam logic [15:0] UNMAPPED_WORD = 16'h0000;
endpackage : weigh_regs_pkg

// file: rtl/status_word_pack.sv
// status word assembly from live scale flags
`timescale 1ns/1ps
`default_nettype none
module status_word_pack (
    input  wire logic        negative_i,
    input  wire logic        stable_i,
    input  wire logic        overflow_i,
    input  wire logic [2:0]  decimals_i,
    input  wire logic        unit_kg_i,
    output logic      [15:0] word_o
);
    // map decimal count 0..4 to its code; out-of-range counts fall back to none
    function automatic logic [2:0] dp_code(input logic [2:0] n);
        unique case (n)
            3'h0:    dp_code = weigh_regs_pkg::DP_NONE;
            3'h1:    dp_code = weigh_regs_pkg::DP_ONE;
            3'h2:    dp_code = weigh_regs_pkg::DP_TWO;
            3'h3:    dp_code = weigh_regs_pkg::DP_THREE;
            3'h4:    dp_code = weigh_regs_pkg::DP_FOUR;
            default: dp_code = weigh_regs_pkg::DP_NONE;
        endcase
    endfunction : dp_code

    // undefined bits read as zero
    always_comb begin
        word_o = 16'h0000;
        word_o[weigh_regs_pkg::ST_SIGN]     = negative_i;
        word_o[weigh_regs_pkg::ST_STABLE]   = stable_i;
        word_o[weigh_regs_pkg::ST_OVERFLOW] = overflow_i;
        word_o[weigh_regs_pkg::ST_DP_MSB:weigh_regs_pkg::ST_DP_LSB] = dp_code(decimals_i);
        word_o[weigh_regs_pkg::ST_UNIT_KG]  = unit_kg_i;
    end
endmodule : status_word_pack
`default_nettype wire

// file: rtl/cmd_pulse_gen.sv
// one-cycle command pulses from a command-register write
`timescale 1ns/1ps
`default_nettype none
module cmd_pulse_gen #(
    parameter int N = 3
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    input  wire logic         fire_i,
    input  wire logic [N-1:0] bits_i,
    output logic      [N-1:0] pulse_o
);
    // each bit fires only on a written one; zero does nothing
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_bit
            always_ff @(posedge mclk_i) begin
                if (!rst_n_i) begin
                    pulse_o[g] <= 1'b0;
                end else begin
                    pulse_o[g] <= fire_i & bits_i[g];
                end
            end
        end
    endgenerate
endmodule : cmd_pulse_gen
`default_nettype wire

// file: rtl/weigh_indicator_modbus_regs.sv
// holding-register bank of the weighing indicator as seen by a modbus master
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - reading the first holding register returns the current gross weight
// - reading the second holding register returns the current tare weight
// - fourth register is status: bit1 stable, bit2 overflow, bit10 kg
// - status bit 0 is the weight sign, set when negative
// - status bits 3..5 hold the decimal-point code 010..110, 010 none, also for counts past four
// - writing one to command bit 0 tares the scale
// - writing one to command bit 1 clears the tare
// - writing one to command bit 2 zeroes the scale
module weigh_indicator_modbus_regs (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        rd_i,
    input  wire logic        wr_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic [15:0] gross_i,
    input  wire logic [15:0] tare_i,
    input  wire logic        negative_i,
    input  wire logic        stable_i,
    input  wire logic        overflow_i,
    input  wire logic [2:0]  decimals_i,
    input  wire logic        unit_kg_i,
    output logic      [15:0] rdata_o,
    output logic             rvalid_o,
    output logic             rerr_o,
    output logic             wack_o,
    output logic             werr_o,
    output logic             tare_o,
    output logic             clear_tare_o,
    output logic             zero_o
);
    logic [15:0] status_word;
    logic        cmd_fire;
    logic [2:0]  cmd_pulse;
    logic [15:0] next_rdata;
    logic        next_rerr;

    status_word_pack u_status (
        .negative_i (negative_i),
        .stable_i   (stable_i),
        .overflow_i (overflow_i),
        .decimals_i (decimals_i),
        .unit_kg_i  (unit_kg_i),
        .word_o     (status_word)
    );

    // only a write to the command register fires; bits 3 and up never reach the pulser
    assign cmd_fire = wr_i && (addr_i == weigh_regs_pkg::ADDR_COMMAND);

    cmd_pulse_gen #(.N(3)) u_cmd (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .fire_i  (cmd_fire),
        .bits_i  (wdata_i[2:0]),
        .pulse_o (cmd_pulse)
    );

    assign tare_o       = cmd_pulse[weigh_regs_pkg::CMD_TARE];
    assign clear_tare_o = cmd_pulse[weigh_regs_pkg::CMD_CLEAR];
    assign zero_o       = cmd_pulse[weigh_regs_pkg::CMD_ZERO];

    // read decode; the write-only command register and holes answer zero with error
    always_comb begin
        next_rdata = weigh_regs_pkg::UNMAPPED_WORD;
        next_rerr  = 1'b0;
        unique case (addr_i)
            weigh_regs_pkg::ADDR_GROSS:  next_rdata = gross_i;
            weigh_regs_pkg::ADDR_TARE:   next_rdata = tare_i;
            weigh_regs_pkg::ADDR_STATUS: next_rdata = status_word;
            default:                     next_rerr  = 1'b1;
        endcase
    end

    // read answer is registered, one cycle after the strobe
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rdata_o  <= weigh_regs_pkg::RESET_WORD;
            rvalid_o <= 1'b0;
            rerr_o   <= 1'b0;
        end else begin
            rvalid_o <= rd_i;
            rerr_o   <= rd_i & next_rerr;
            if (rd_i) begin
                rdata_o <= next_rdata;
            end
        end
    end

    // write acknowledge; writes to read-only registers are flagged, not stored
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            wack_o <= 1'b0;
            werr_o <= 1'b0;
        end else begin
            wack_o <= wr_i;
            werr_o <= wr_i & ~cmd_fire;
        end
    end

    a_gross_read: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        rd_i && addr_i == weigh_regs_pkg::ADDR_GROSS |=> rvalid_o && rdata_o == $past(gross_i))
        else $error("gross read wrong");
    a_tare_read: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        rd_i && addr_i == weigh_regs_pkg::ADDR_TARE |=> rdata_o == $past(tare_i) && !rerr_o)
        else $error("tare read wrong");
    a_status_flags: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        rd_i && addr_i == weigh_regs_pkg::ADDR_STATUS |=>
        rdata_o[1] == $past(stable_i) && rdata_o[2] == $past(overflow_i)
        && rdata_o[10] == $past(unit_kg_i) && rdata_o[15:11] == 5'h00 && rdata_o[9:6] == 4'h0)
        else $error("status flags wrong");
    a_status_sign: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        rd_i && addr_i == weigh_regs_pkg::ADDR_STATUS |=> rdata_o[0] == $past(negative_i))
        else $error("sign bit wrong");
    a_status_dp: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        rd_i && addr_i == weigh_regs_pkg::ADDR_STATUS && decimals_i <= 3'h4 |=>
        rdata_o[5:3] == $past(decimals_i) + 3'h2)
        else $error("decimal code wrong");

    sequence s_cmd_write(int b);
        wr_i && addr_i == weigh_regs_pkg::ADDR_COMMAND && wdata_i[b];
    endsequence
    a_tare_pulse: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        s_cmd_write(0) |=> tare_o ##1 !tare_o || $past(cmd_fire && wdata_i[0]))
        else $error("tare pulse wrong");
    a_clear_pulse: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        s_cmd_write(1) |=> clear_tare_o)
        else $error("clear pulse missing");
    a_zero_pulse: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        s_cmd_write(2) |=> zero_o)
        else $error("zero pulse missing");
    a_no_spurious: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !(wr_i && addr_i == weigh_regs_pkg::ADDR_COMMAND) |=> !tare_o && !clear_tare_o && !zero_o)
        else $error("spurious command pulse");

    // bus answer timing: one answer per strobe, on the very next edge, never otherwise
    sequence s_any_read;
        rd_i;
    endsequence
    sequence s_any_write;
        wr_i;
    endsequence
    sequence s_status_read;
        rd_i && addr_i == weigh_regs_pkg::ADDR_STATUS;
    endsequence
    sequence s_cmd_read;
        rd_i && addr_i == weigh_regs_pkg::ADDR_COMMAND;
    endsequence
    a_read_answer: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        s_any_read |=> rvalid_o)
        else $error("read not answered");
    // read data must stand untouched between reads, a master may fetch it late
    a_read_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !rd_i |=> !rvalid_o && !rerr_o && $stable(rdata_o))
        else $error("read answer without strobe");
    a_write_answer: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        s_any_write |=> wack_o)
        else $error("write not acknowledged");
    a_write_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !wr_i |=> !wack_o && !werr_o)
        else $error("write answer without strobe");
    // a write to a read-only word is flagged and never reaches the scale
    a_write_refused: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        wr_i && addr_i != weigh_regs_pkg::ADDR_COMMAND |=>
        werr_o && !tare_o && !clear_tare_o && !zero_o)
        else $error("read-only write not refused");
    a_cmd_read_refused: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        s_cmd_read |=> rerr_o && rdata_o == weigh_regs_pkg::UNMAPPED_WORD)
        else $error("command register read not refused");
    a_cmd_zero_ignored: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        wr_i && addr_i == weigh_regs_pkg::ADDR_COMMAND && wdata_i[2:0] == 3'h0 |=>
        !tare_o && !clear_tare_o && !zero_o)
        else $error("zero command bits fired");
    // counts past four fall back to the no-decimals code
    a_status_dp_alt: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        rd_i && addr_i == weigh_regs_pkg::ADDR_STATUS && decimals_i > 3'h4 |=>
        rdata_o[5:3] == weigh_regs_pkg::DP_NONE)
        else $error("decimal fallback code wrong");
    a_status_read_ok: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        s_status_read |=> rvalid_o && !rerr_o)
        else $error("status read refused");
    a_clear_single: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        clear_tare_o |=> !clear_tare_o || $past(cmd_fire && wdata_i[1]))
        else $error("clear pulse stretched");
    a_zero_single: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        zero_o |=> !zero_o || $past(cmd_fire && wdata_i[2]))
        else $error("zero pulse stretched");
endmodule : weigh_indicator_modbus_regs
`default_nettype wire

// file: sim/modbus_master_model.sv
// modbus master stand-in driving the register strobes of the bank
`timescale 1ns/1ps
`default_nettype none
module modbus_master_model (
    input  wire logic        mclk_i,
    output logic             rd_o,
    output logic             wr_o,
    output logic      [15:0] addr_o,
    output logic      [15:0] wdata_o
);
    initial begin
        rd_o = 1'b0;
        wr_o = 1'b0;
        addr_o = 16'h0000;
        wdata_o = 16'h0000;
    end

    // one-cycle strobe; released lines show the inverse so stale values never pass
    task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk_i) #1;
        rd_o = ~w;
        wr_o = w;
        addr_o = a;
        wdata_o = d;
        @(posedge mclk_i) #1;
        rd_o = 1'b0;
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask : access

    // two requests on consecutive edges, then release; exercises back-to-back service
    task automatic pair(input logic w0, input logic [15:0] a0, input logic [15:0] d0,
                        input logic w1, input logic [15:0] a1, input logic [15:0] d1);
        @(posedge mclk_i) #1;
        rd_o = ~w0;
        wr_o = w0;
        addr_o = a0;
        wdata_o = d0;
        @(posedge mclk_i) #1;
        rd_o = ~w1;
        wr_o = w1;
        addr_o = a1;
        wdata_o = d1;
        @(posedge mclk_i) #1;
        rd_o = 1'b0;
        wr_o = 1'b0;
        addr_o = ~a1;
        wdata_o = ~d1;
    endtask : pair
endmodule : modbus_master_model
`default_nettype wire

// file: sim/tb_top.sv
// self-checking bench for the holding-register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {logic w; logic [15:0] a; logic [15:0] d; logic [23:0] e;} row_t;
    logic        mclk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        rd, wr, rvalid, rerr, wack, werr, tare_p, clr_p, zero_p;
    logic [15:0] addr, wdata, rdata;
    logic [15:0] gross = 16'h1234;
    logic [15:0] tare = 16'h0056;
    logic        neg = 1'b1, stable = 1'b1, ovf = 1'b0, kg = 1'b1;
    logic [2:0]  dec = 3'h2;
    int          err_total = 0, num_checks = 0, cycles = 0;
    // expected field: ack nibble, read data, then {err, tare, clear, zero}
    row_t rows [11] = '{
        '{1'b0, 16'h9c41, 16'h0000, 24'h112340},
        '{1'b0, 16'h9c42, 16'h0000, 24'h100560},
        '{1'b0, 16'h9c44, 16'h0000, 24'h104230},
        '{1'b0, 16'h9c43, 16'h0000, 24'h100008},
        '{1'b0, 16'h0000, 16'h0000, 24'h100008},
        '{1'b1, 16'h9c43, 16'h0001, 24'h100004},
        '{1'b1, 16'h9c43, 16'h0002, 24'h100002},
        '{1'b1, 16'h9c43, 16'h0004, 24'h100001},
        '{1'b1, 16'h9c43, 16'hfff8, 24'h100000},
        '{1'b1, 16'h9c41, 16'h0001, 24'h100008},
        '{1'b1, 16'h9c43, 16'h0007, 24'h100007}
    };

    always #2 mclk_i = ~mclk_i;

    modbus_master_model mm (.mclk_i(mclk_i), .rd_o(rd), .wr_o(wr), .addr_o(addr), .wdata_o(wdata));

    weigh_indicator_modbus_regs dut (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .rd_i(rd), .wr_i(wr), .addr_i(addr),
        .wdata_i(wdata), .gross_i(gross), .tare_i(tare), .negative_i(neg),
        .stable_i(stable), .overflow_i(ovf), .decimals_i(dec), .unit_kg_i(kg),
        .rdata_o(rdata), .rvalid_o(rvalid), .rerr_o(rerr), .wack_o(wack), .werr_o(werr),
        .tare_o(tare_p), .clear_tare_o(clr_p), .zero_o(zero_p)
    );

    task automatic end_sim;
        if (err_total == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // one access, then the answer is looked at in the cycle it stands
    task automatic run(input row_t r);
        mm.access(r.w, r.a, r.d);
        chk({3'h0, r.w ? wack : rvalid, r.w ? 16'h0000 : rdata, r.w ? werr : rerr,
             tare_p, clr_p, zero_p}, r.e);
    endtask : run

    // hang guard, the whole run needs well under a hundred cycles
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 500) begin
            err_total++;
            end_sim();
        end
    end

    initial begin
        repeat (2) @(posedge mclk_i);
        #1;
        chk({2'h0, wack, rvalid, rdata, werr | rerr, tare_p, clr_p, zero_p}, 24'h0);
        rst_n_i = 1'b1;
        foreach (rows[i]) run(rows[i]);
        @(posedge mclk_i) #1;
        // pulses of the last command write must already be gone
        chk({21'h0, tare_p, clr_p, zero_p}, 24'h0);
        // back-to-back tare writes give a pulse on each of two edges
        fork
            mm.pair(1'b1, 16'h9c43, 16'h0001, 1'b1, 16'h9c43, 16'h0001);
            begin
                repeat (2) @(posedge mclk_i);
                #1;
                chk({22'h0, wack, tare_p}, 24'h3);
            end
        join
        chk({22'h0, wack, tare_p}, 24'h3);
        @(posedge mclk_i) #1;
        chk({22'h0, wack, tare_p}, 24'h0);
        // read data stands through a later write until the next read
        fork
            mm.pair(1'b0, 16'h9c42, 16'h0000, 1'b1, 16'h9c43, 16'h0002);
            begin
                repeat (2) @(posedge mclk_i);
                #1;
                chk({7'h0, rvalid, rdata}, {8'h01, 16'h0056});
            end
        join
        chk({3'h0, wack, rdata, 3'h0, clr_p}, {4'h1, 16'h0056, 4'h1});
        neg = 1'b0;
        stable = 1'b0;
        ovf = 1'b1;
        kg = 1'b0;
        // each decimal count 0..4 maps onto its own point code; counts past four mean none
        for (int k = 0; k < 8; k++) begin
            dec = 3'(k);
            run('{1'b0, 16'h9c44, 16'h0000,
                  {4'h1, 16'h0004 | ((k < 5) ? 16'(k) + 16'h2 : 16'h2) << 3, 4'h0}});
        end
        // reset in mid-run clears every output, read data included
        rst_n_i = 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
        chk({2'h0, wack, rvalid, rdata, werr | rerr, tare_p, clr_p, zero_p}, 24'h0);
        rst_n_i = 1'b1;
        run(rows[0]);
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
